// File: hw/timer_pkg.sv
package timer_pkg;

	localparam logic [7:0]  DIR_RESET        = 8'hFF;
	localparam logic [7:0]  PRESCALER_RESET  = 8'h00;
	localparam logic [7:0]  MODE_RESET       = 8'h00;
	localparam logic [7:0]  CAPTURE_RESET    = 8'h00;
	localparam logic [15:0] COMPARE_RESET    = 16'h0000;
	localparam logic [15:0] COUNT_ALL_ONES   = 16'hFFFF;

	// Prescaler mode register fields
	localparam int CLK_SEL_LSB    = 0;
	localparam int EDGE_EVENT_LSB = 4;
	localparam int EDGE_SECOND_LSB = 6;

	// Mode control register field
	localparam int MODE_LSB = 2;

	// Capture control register fields
	localparam int CAP_FIRST_EN_BIT = 0;

	// Direction register bits of the two timer pins
	localparam int DIR_EVENT_BIT  = 0;
	localparam int DIR_SHARED_BIT = 1;

	// Count clock dividers of the peripheral clock, as shift amounts
	localparam int DIV_MID_SHIFT  = 2;
	localparam int DIV_SLOW_SHIFT = 8;
	localparam int DIV_WIDTH      = 8;

	typedef enum logic [1:0]
	{
		CLK_SEL_FULL  = 2'h0,
		CLK_SEL_MID   = 2'h1,
		CLK_SEL_SLOW  = 2'h2,
		CLK_SEL_EVENT = 2'h3
	} clk_sel_t;

	typedef enum logic [1:0]
	{
		EDGE_FALL = 2'h0,
		EDGE_RISE = 2'h1,
		EDGE_BAD  = 2'h2,
		EDGE_BOTH = 2'h3
	} edge_sel_t;

	typedef enum logic [1:0]
	{
		MODE_STOP    = 2'h0,
		MODE_FREE    = 2'h1,
		MODE_RESTART = 2'h2,
		MODE_MATCH   = 2'h3
	} run_mode_t;

endpackage : timer_pkg

// File: hw/edge_filter.sv
module edge_filter
(
	input  wire logic                 sys_clk_i,  // Peripheral clock
	input  wire logic                 nrst_i,     // Synchronous reset, active low
	input  wire logic                 clear_i,    // Timer stopped
	input  wire logic                 sample_i,   // Sampling strobe
	input  wire logic                 pin_i,      // Raw pin level
	input  wire timer_pkg::edge_sel_t edge_sel_i, // Valid edge choice
	output logic                      edge_o      // Filtered valid edge pulse
);
	import timer_pkg::*;

	typedef struct packed
	{
		logic samp;
		logic level;
		logic edge_p;
	} filt_state_t;

	filt_state_t st_reg;
	filt_state_t st_next;

	always_comb
	begin
		st_next        = st_reg;
		st_next.edge_p = 1'b0;
		if (clear_i)
		begin
			st_next.samp  = 1'b0;
			st_next.level = 1'b0;
		end
		else if (sample_i)
		begin
			st_next.samp = pin_i;
			// New level accepted only after two equal samples
			if ((st_reg.samp == pin_i) && (pin_i != st_reg.level))
			begin
				st_next.level = pin_i;
				case (edge_sel_i)
					EDGE_FALL: st_next.edge_p = ~pin_i;
					EDGE_RISE: st_next.edge_p = pin_i;
					EDGE_BOTH: st_next.edge_p = 1'b1;
					default:   st_next.edge_p = 1'b0;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign edge_o = st_reg.edge_p;

endmodule : edge_filter

// File: hw/timer_event_counter_capture.sv
// Operation
// - Direction register resets to all ones
// - Direction bit 0 drives, 1 releases
// - Match clears counter, keeps counting, interrupts
// - Count clock from prescaler bits 1:0
// - Match mode: overflow only when compare is all ones
// - Interval is compare plus one ticks
// - Compare below count: run to overflow
// - Event mode counts each valid edge
// - Event edge chosen by prescaler bits 5:4
// - Event input filtered on peripheral clock
// - Counting starts after twice-seen valid edge
// - Free-running and restart-on-edge pulse measurement
// - Capture inputs sampled on count clock
// - Free-running edge captures counter, interrupts
// - Edge codes: 00 fall, 01 rise, 11 both
module timer_event_counter_capture
(
	input  wire logic        SYS_CLK_I,          // Peripheral clock, 40 MHz
	input  wire logic        NRST_I,             // Synchronous reset, active low
	input  wire logic        DIR_WR_I,           // Direction register write strobe
	input  wire logic [7:0]  DIR_WDATA_I,        // Direction register write data
	input  wire logic        PRESCALER_WR_I,     // Prescaler mode register write strobe
	input  wire logic [7:0]  PRESCALER_WDATA_I,  // Prescaler mode register write data
	input  wire logic        MODE_WR_I,          // Mode control register write strobe
	input  wire logic [7:0]  MODE_WDATA_I,       // Mode control register write data
	input  wire logic        CAPTURE_WR_I,       // Capture control register write strobe
	input  wire logic [7:0]  CAPTURE_WDATA_I,    // Capture control register write data
	input  wire logic        COMPARE_WR_I,       // Compare register write strobe
	input  wire logic [15:0] COMPARE_WDATA_I,    // Compare register write data
	input  wire logic        OVERFLOW_CLR_I,     // Overflow flag clear pulse
	input  wire logic        EVENT_PIN_I,        // Event input pin level
	input  wire logic        SECOND_PIN_I,       // Second capture pin level
	output logic [7:0]       DIR_O,              // Direction register contents
	output logic [7:0]       PIN_OE_O,           // Output buffer enables per pin
	output logic             TIMER_OUT_O,        // Timer output pin level
	output logic [7:0]       PRESCALER_O,        // Prescaler mode register contents
	output logic [7:0]       MODE_O,             // Mode control register contents
	output logic [7:0]       CAPTURE_CTL_O,      // Capture control register contents
	output logic [15:0]      MAIN_COUNTER_O,     // Main counter value
	output logic [15:0]      COMPARE_FIRST_O,    // Compare or first capture register
	output logic [15:0]      CAPTURE_SECOND_O,   // Second capture register
	output logic             OVERFLOW_FLAG_O,    // Overflow flag
	output logic             MATCH_IRQ_O,        // Match interrupt request pulse
	output logic             CAPTURE_IRQ_O       // Capture interrupt request pulse
);
	import timer_pkg::*;

	typedef struct packed
	{
		logic [7:0]           dir;
		logic [7:0]           prescaler;
		logic [7:0]           mode;
		logic [7:0]           cap_ctl;
		logic [15:0]          compare;
		logic [15:0]          capture;
		logic [15:0]          counter;
		logic [DIV_WIDTH-1:0] div;
		logic                 ovf;
		logic                 match_p;
		logic                 capture_p;
	} timer_state_t;

	timer_state_t st_reg;
	timer_state_t st_next;

	run_mode_t run_mode;
	clk_sel_t  clk_sel;
	edge_sel_t edge_event;
	edge_sel_t edge_second;
	logic      stopped;
	logic      div_tick;
	logic      event_sample;
	logic      event_edge;
	logic      second_edge;
	logic      count_tick;

	assign run_mode    = run_mode_t'(st_reg.mode[MODE_LSB +: 2]);
	assign clk_sel     = clk_sel_t'(st_reg.prescaler[CLK_SEL_LSB +: 2]);
	assign edge_event  = edge_sel_t'(st_reg.prescaler[EDGE_EVENT_LSB +: 2]);
	assign edge_second = edge_sel_t'(st_reg.prescaler[EDGE_SECOND_LSB +: 2]);
	assign stopped     = (run_mode == MODE_STOP);

	// Divided count clock strobe
	always_comb
	begin
		case (clk_sel)
			CLK_SEL_FULL:  div_tick = 1'b1;
			CLK_SEL_MID:   div_tick = (st_reg.div[DIV_MID_SHIFT-1:0] == '0);
			CLK_SEL_SLOW:  div_tick = (st_reg.div == '0);
			default:       div_tick = 1'b1;
		endcase
	end

	// Event counting samples on every peripheral clock, capture on the count clock
	assign event_sample = (clk_sel == CLK_SEL_EVENT) ? 1'b1 : div_tick;

	edge_filter u_event_filter
	(
		.sys_clk_i  (SYS_CLK_I),
		.nrst_i     (NRST_I),
		.clear_i    (stopped),
		.sample_i   (event_sample),
		.pin_i      (EVENT_PIN_I),
		.edge_sel_i (edge_event),
		.edge_o     (event_edge)
	);

	edge_filter u_second_filter
	(
		.sys_clk_i  (SYS_CLK_I),
		.nrst_i     (NRST_I),
		.clear_i    (stopped),
		.sample_i   (div_tick),
		.pin_i      (SECOND_PIN_I),
		.edge_sel_i (edge_second),
		.edge_o     (second_edge)
	);

	// External edges become the count clock when selected
	assign count_tick = (clk_sel == CLK_SEL_EVENT) ? event_edge : div_tick;

	always_comb
	begin
		st_next           = st_reg;
		st_next.match_p   = 1'b0;
		st_next.capture_p = 1'b0;

		if (DIR_WR_I)
			st_next.dir = DIR_WDATA_I;
		if (PRESCALER_WR_I)
			st_next.prescaler = PRESCALER_WDATA_I;
		if (MODE_WR_I)
			st_next.mode = MODE_WDATA_I;
		if (CAPTURE_WR_I)
			st_next.cap_ctl = CAPTURE_WDATA_I;
		if (COMPARE_WR_I)
			st_next.compare = COMPARE_WDATA_I;
		if (OVERFLOW_CLR_I)
			st_next.ovf = 1'b0;

		if (stopped)
		begin
			st_next.counter = '0;
			st_next.div     = '0;
		end
		else
		begin
			st_next.div = st_reg.div + 1'b1;

			if (count_tick)
			begin
				if ((run_mode == MODE_MATCH) && (st_reg.counter == st_reg.compare))
				begin
					st_next.counter = '0;
					st_next.match_p = 1'b1;
				end
				else
					st_next.counter = st_reg.counter + 1'b1;

				if (st_reg.counter == COUNT_ALL_ONES)
				begin
					if ((run_mode != MODE_MATCH) || (st_reg.compare == COUNT_ALL_ONES))
						st_next.ovf = 1'b1;
				end
			end

			// Capture on the event pin; restart mode also clears the counter
			if ((run_mode == MODE_FREE) || (run_mode == MODE_RESTART))
			begin
				if (event_edge && (clk_sel != CLK_SEL_EVENT))
				begin
					st_next.capture   = st_reg.counter;
					st_next.capture_p = 1'b1;
					if (run_mode == MODE_RESTART)
						st_next.counter = '0;
				end
				if (second_edge)
				begin
					if (st_reg.cap_ctl[CAP_FIRST_EN_BIT])
						st_next.compare = st_reg.counter;
					st_next.match_p = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge SYS_CLK_I)
	begin
		if (!NRST_I)
		begin
			st_reg           <= '0;
			st_reg.dir       <= DIR_RESET;
			st_reg.prescaler <= PRESCALER_RESET;
			st_reg.mode      <= MODE_RESET;
			st_reg.cap_ctl   <= CAPTURE_RESET;
			st_reg.compare   <= COMPARE_RESET;
		end
		else
			st_reg <= st_next;
	end

	assign DIR_O            = st_reg.dir;
	assign PIN_OE_O         = ~st_reg.dir;
	assign TIMER_OUT_O      = 1'b0;
	assign PRESCALER_O      = st_reg.prescaler;
	assign MODE_O           = st_reg.mode;
	assign CAPTURE_CTL_O    = st_reg.cap_ctl;
	assign MAIN_COUNTER_O   = st_reg.counter;
	assign COMPARE_FIRST_O  = st_reg.compare;
	assign CAPTURE_SECOND_O = st_reg.capture;
	assign OVERFLOW_FLAG_O  = st_reg.ovf;
	assign MATCH_IRQ_O      = st_reg.match_p;
	assign CAPTURE_IRQ_O    = st_reg.capture_p;

endmodule : timer_event_counter_capture

// File: testbench/timer_checker_assertions.sv
module timer_checker
(
	input wire logic        SYS_CLK_I,        // Clock
	input wire logic        NRST_I,           // Reset
	input wire logic [7:0]  DIR_O,            // Direction
	input wire logic [7:0]  PIN_OE_O,         // Enables
	input wire logic [7:0]  PRESCALER_O,      // Prescaler
	input wire logic [7:0]  MODE_O,           // Mode
	input wire logic [15:0] MAIN_COUNTER_O,   // Counter
	input wire logic [15:0] COMPARE_FIRST_O,  // Compare
	input wire logic [15:0] CAPTURE_SECOND_O, // Capture
	input wire logic        OVERFLOW_FLAG_O,  // Overflow
	input wire logic        MATCH_IRQ_O,      // Match pulse
	input wire logic        CAPTURE_IRQ_O     // Capture pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!NRST_I);
	wire logic run_m = (MODE_O[3:2] == 2'h3);
	wire logic sel0  = (PRESCALER_O[1:0] == 2'h0);
	property p_dir_reset;
		$rose(NRST_I) |-> DIR_O == 8'hFF && PIN_OE_O == 8'h00;
	endproperty
	a_dir_reset: assert property (p_dir_reset) else $error("direction not ones");
	property p_oe;
		PIN_OE_O == ~DIR_O;
	endproperty
	a_oe: assert property (p_oe) else $error("enable mismatch");
	property p_stop;
		MODE_O[3:2] == 2'h0 |=> MAIN_COUNTER_O == 16'h0000 && !MATCH_IRQ_O && !CAPTURE_IRQ_O;
	endproperty
	a_stop: assert property (p_stop) else $error("stopped timer active");
	property p_match;
		run_m && sel0 && COMPARE_FIRST_O != 16'h0000 && MAIN_COUNTER_O == COMPARE_FIRST_O
			|=> MAIN_COUNTER_O == 16'h0000 && MATCH_IRQ_O;
	endproperty
	a_match: assert property (p_match) else $error("match did not clear");
	sequence s_gap;
		(run_m && COMPARE_FIRST_O == 16'h0002 && !MATCH_IRQ_O)[*2];
	endsequence
	property p_period;
		MATCH_IRQ_O && sel0 ##1 s_gap ##1 run_m |-> MATCH_IRQ_O;
	endproperty
	a_period: assert property (p_period) else $error("interval wrong");
	property p_ovf;
		run_m && COMPARE_FIRST_O != 16'hFFFF && !OVERFLOW_FLAG_O |=> !OVERFLOW_FLAG_O;
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow set");
	property p_step;
		run_m && $past(run_m) && MAIN_COUNTER_O != $past(MAIN_COUNTER_O)
			|-> MAIN_COUNTER_O == $past(MAIN_COUNTER_O) + 16'h0001 || MAIN_COUNTER_O == 16'h0000;
	endproperty
	a_step: assert property (p_step) else $error("counter jumped");
	property p_capture;
		CAPTURE_IRQ_O |-> CAPTURE_SECOND_O == $past(MAIN_COUNTER_O);
	endproperty
	a_capture: assert property (p_capture) else $error("capture value wrong");
endmodule : timer_checker

bind timer_event_counter_capture timer_checker chk_u
(
	.SYS_CLK_I(SYS_CLK_I),
	.NRST_I(NRST_I),
	.DIR_O(DIR_O),
	.PIN_OE_O(PIN_OE_O),
	.PRESCALER_O(PRESCALER_O),
	.MODE_O(MODE_O),
	.MAIN_COUNTER_O(MAIN_COUNTER_O),
	.COMPARE_FIRST_O(COMPARE_FIRST_O),
	.CAPTURE_SECOND_O(CAPTURE_SECOND_O),
	.OVERFLOW_FLAG_O(OVERFLOW_FLAG_O),
	.MATCH_IRQ_O(MATCH_IRQ_O),
	.CAPTURE_IRQ_O(CAPTURE_IRQ_O)
);

// File: testbench/pulse_source.sv
module pulse_source
(
	input  wire logic       sys_clk_i, // Clock
	input  wire logic [1:0] oe_i,      // Pin buffer enables
	output logic            event_o,   // Event pin
	output logic            second_o   // Second pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic ev_lvl = 1'b0;
	logic sec_lvl = 1'b0;
	// A pin driven by the device no longer shows the source level
	assign event_o = oe_i[0] ? 1'b0 : ev_lvl;
	assign second_o = oe_i[1] ? 1'b0 : sec_lvl;
	task automatic pulse(input int hi, input int lo);
		ev_lvl = 1'b1;
		repeat (hi) @(negedge sys_clk_i);
		ev_lvl = 1'b0;
		repeat (lo) @(negedge sys_clk_i);
	endtask : pulse
	task automatic pulse2(input int hi, input int lo);
		sec_lvl = 1'b1;
		repeat (hi) @(negedge sys_clk_i);
		sec_lvl = 1'b0;
		repeat (lo) @(negedge sys_clk_i);
	endtask : pulse2
endmodule : pulse_source

// File: testbench/test_timer_event_counter_capture.sv
module test_timer_event_counter_capture;
	timeunit 1ns;
	timeprecision 1ps;
	import timer_pkg::*;
	logic sys_clk, nrst, dir_wr, pre_wr, mode_wr, cap_wr, cmp_wr, ovf_clr, ev_pin, sec_pin;
	logic [7:0] dir_wd, pre_wd, mode_wd, cap_wd, dir, oe, pre, mode, capctl;
	logic [15:0] cmp_wd, cnt, cmp, cap2;
	logic tout, ovf, mirq, cirq;
	int n_errors, n_checks, cycles;
	timer_event_counter_capture dut_u
	(
		.SYS_CLK_I(sys_clk), .NRST_I(nrst), .DIR_WR_I(dir_wr), .DIR_WDATA_I(dir_wd),
		.PRESCALER_WR_I(pre_wr), .PRESCALER_WDATA_I(pre_wd), .MODE_WR_I(mode_wr),
		.MODE_WDATA_I(mode_wd), .CAPTURE_WR_I(cap_wr), .CAPTURE_WDATA_I(cap_wd),
		.COMPARE_WR_I(cmp_wr), .COMPARE_WDATA_I(cmp_wd), .OVERFLOW_CLR_I(ovf_clr),
		.EVENT_PIN_I(ev_pin), .SECOND_PIN_I(sec_pin), .DIR_O(dir), .PIN_OE_O(oe),
		.TIMER_OUT_O(tout), .PRESCALER_O(pre), .MODE_O(mode), .CAPTURE_CTL_O(capctl),
		.MAIN_COUNTER_O(cnt), .COMPARE_FIRST_O(cmp), .CAPTURE_SECOND_O(cap2),
		.OVERFLOW_FLAG_O(ovf), .MATCH_IRQ_O(mirq), .CAPTURE_IRQ_O(cirq)
	);
	pulse_source src_u
	(
		.sys_clk_i(sys_clk), .oe_i(oe[1:0]), .event_o(ev_pin), .second_o(sec_pin)
	);
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input int r, input logic [15:0] d);
		{dir_wr, pre_wr, mode_wr, cap_wr, cmp_wr} = 5'h10 >> r;
		{dir_wd, pre_wd, mode_wd, cap_wd} = {4{d[7:0]}};
		cmp_wd = d;
		@(negedge sys_clk);
		{dir_wr, pre_wr, mode_wr, cap_wr, cmp_wr} = 5'h00;
		// Idle cycle so back-to-back writes never retoggle a strobe at once
		@(negedge sys_clk);
	endtask : wr
	task automatic t_regs;
		chk("dir", 16'h00FF, 16'(dir));
		chk("pre", 16'h0000, 16'(pre));
		chk("tout", 16'h0000, 16'(tout));
		wr(0, 16'h00FC);
		chk("oe", 16'h0003, 16'(oe));
		wr(0, 16'h00FF);
		chk("oe", 16'h0000, 16'(oe));
	endtask : t_regs
	task automatic t_interval;
		int n, k, p;
		for (int s = 0; s < 3; s++)
		begin
			p = 3 << (s == 2 ? 8 : 2 * s);
			wr(2, 16'h0000);
			wr(1, 16'(s));
			wr(4, 16'h0002);
			wr(2, 16'h000C);
			for (k = 0; mirq !== 1'b1 && k < 2 * p; k++) @(negedge sys_clk);
			n = 0;
			repeat (2 * p)
			begin
				@(negedge sys_clk);
				n += (mirq === 1'b1);
			end
			chk("irqs", 16'h0002, 16'(n));
		end
		wr(2, 16'h0000);
		@(negedge sys_clk);
		chk("stopped", 16'h0000, cnt);
	endtask : t_interval
	task automatic t_event;
		logic [15:0] ex [4] = '{16'h0002, 16'h0002, 16'h0000, 16'h0004};
		for (int e = 0; e < 4; e++)
		begin
			wr(2, 16'h0000);
			wr(1, {10'h000, 2'(e), 4'h3});
			wr(4, 16'h0007);
			wr(2, 16'h000C);
			src_u.pulse(1, 6);
			src_u.pulse(4, 4);
			src_u.pulse(4, 8);
			chk("events", ex[e], cnt);
		end
	endtask : t_event
	task automatic t_capture;
		logic [15:0] v [$];
		wr(2, 16'h0000);
		wr(1, 16'h0030);
		wr(3, 16'h0000);
		chk("capctl", 16'h0000, 16'(capctl));
		for (int m = 4; m <= 8; m += 4)
		begin
			v.delete();
			wr(2, 16'h0000);
			wr(2, 16'(m));
			fork
				src_u.pulse(20, 12);
				repeat (32)
				begin
					@(negedge sys_clk);
					if (cirq === 1'b1) v.push_back(cap2);
					if (cirq === 1'b1 && m == 8) chk("restart", 16'h0000, cnt);
				end
			join
			chk("captures", 16'h0002, 16'(v.size()));
			if (m == 4) chk("width", 16'h0014, v[1] - v[0]);
		end
	endtask : t_capture
	task automatic t_second;
		int n;
		wr(2, 16'h0000);
		wr(1, 16'h0040);
		wr(3, 16'h0001);
		wr(2, 16'h0004);
		chk("mode", 16'h0004, 16'(mode));
		n = 0;
		fork
			src_u.pulse2(4, 4);
			repeat (8)
			begin
				@(negedge sys_clk);
				n += (mirq === 1'b1);
			end
		join
		chk("second irq", 16'h0001, 16'(n));
		chk("second cap", 16'h0003, cmp);
		wr(2, 16'h0000);
	endtask : t_second
	task automatic t_wrap;
		int n;
		wr(2, 16'h0000);
		wr(1, 16'h0000);
		wr(4, 16'h0010);
		wr(2, 16'h000C);
		while (cnt !== 16'h0005) @(negedge sys_clk);
		wr(4, 16'h0003);
		chk("cmp", 16'h0003, cmp);
		n = 0;
		for (int k = 0; cnt !== 16'h0000 && k < 70000; k++)
		begin
			@(negedge sys_clk);
			n += (mirq === 1'b1);
		end
		chk("early match", 16'h0000, 16'(n));
		chk("ovf", 16'h0000, 16'(ovf));
		wr(2, 16'h0000);
	endtask : t_wrap
	task automatic final_report;
		if (n_errors == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report
	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 90000)
		begin
			n_errors++;
			final_report();
		end
	end
	initial
	begin
		nrst = 1'b0;
		{dir_wr, pre_wr, mode_wr, cap_wr, cmp_wr, ovf_clr} = 6'h00;
		{dir_wd, pre_wd, mode_wd, cap_wd} = 32'h0000_0000;
		cmp_wd = 16'h0000;
		repeat (20) @(negedge sys_clk);
		nrst = 1'b1;
		t_regs();
		t_interval();
		t_event();
		t_capture();
		t_second();
		t_wrap();
		final_report();
	end
endmodule : test_timer_event_counter_capture
